// ==== logic/cfp_inquiry_defines.svh ====
// offsets, field positions, codes and reset values for the inquiry bank
`ifndef CFP_INQUIRY_DEFINES_SVH
`define CFP_INQUIRY_DEFINES_SVH

// address width of the register slave
`define CFP_ADDR_W 12

// register byte offsets
`define CFP_OFS_FEAT_HI 12'h404
`define CFP_OFS_FEAT_LO 12'h408
`define CFP_OFS_OPT_FN 12'h40C
`define CFP_OFS_ADV_PTR 12'h480
`define CFP_OFS_PIO_PTR 12'h484
`define CFP_OFS_STROBE_PTR 12'h48C
`define CFP_OFS_VID_SEL 12'h7F0

// feature-high field numbers, bit 0 is the quadlet msb
`define CFP_FB_BRIGHTNESS 0
`define CFP_FB_AUTO_EXPOSURE 1
`define CFP_FB_SHARPNESS 2
`define CFP_FB_WHITE_BALANCE 3
`define CFP_FB_HUE 4
`define CFP_FB_SATURATION 5
`define CFP_FB_GAMMA 6
`define CFP_FB_SHUTTER 7
`define CFP_FB_GAIN 8
`define CFP_FB_IRIS 9
`define CFP_FB_FOCUS 10
`define CFP_FB_TEMPERATURE 11
`define CFP_FB_TRIGGER 12
`define CFP_FB_TRIGGER_DELAY 13
`define CFP_FB_WHITE_SHADING 14
`define CFP_FB_FRAME_PRIO 15

// feature-low field numbers
`define CFP_FB_ZOOM 0
`define CFP_FB_PAN 1
`define CFP_FB_TILT 2
`define CFP_FB_OPT_FILTER 3
`define CFP_FB_CAPTURE_SIZE 16
`define CFP_FB_CAPTURE_QUALITY 17

// optional-function field numbers
`define CFP_FB_PARALLEL_IO 1
`define CFP_FB_SERIAL_IO 2
`define CFP_FB_STROBE 3

// model variants
`define CFP_VARIANT_MONO 1
`define CFP_VARIANT_COLOUR 2

// video selection register layout and reset values
`define CFP_SEL_MODE_LSB 0
`define CFP_SEL_FMT_LSB 8
`define CFP_SEL_RESET 3'h0
`define CFP_MONO_FMT 3'h7
`define CFP_MONO_MODE 3'h0

// axi response codes
`define CFP_RESP_OKAY 2'h0
`define CFP_RESP_SLVERR 2'h2

`endif

// ==== logic/cfp_inquiry_pkg.sv ====
// types shared by the inquiry bank
package cfp_inquiry_pkg;

   typedef logic [31:0] cfp_quad_t;
   typedef logic [2:0] cfp_sel_t;

   typedef enum logic {
      CFP_WR_IDLE,
      CFP_WR_RESP
   } cfp_wr_state_e;

   typedef enum logic {
      CFP_RD_IDLE,
      CFP_RD_DATA
   } cfp_rd_state_e;

endpackage

// ==== logic/cfp_reset_sync.sv ====
// reset release synchroniser
`timescale 1ns/1ps
module cfp_reset_sync (
   input wire logic clk_i, // system clock
   input wire logic arst_n_i, // async reset, active low
   output logic rst_n_o // synchronised reset, active low
);

   logic meta_q;
   logic hold_q;

   // assert at once, release two edges later to avoid a metastable release
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= 1'b0;
         hold_q <= 1'b0;
      end else begin
         meta_q <= 1'b1;
         hold_q <= meta_q;
      end
   end

   assign rst_n_o = hold_q;

endmodule // cfp_reset_sync

// ==== logic/cfp_feature_inquiry.sv ====
// camera feature presence inquiry bank behind an axi4-lite slave
`timescale 1ns/1ps
`include "cfp_inquiry_defines.svh"

module cfp_feature_inquiry
   import cfp_inquiry_pkg::*;
#(
   parameter int MODEL_VARIANT = `CFP_VARIANT_MONO,
   parameter cfp_quad_t VENDOR_BLOCK_OFS = 32'h0000_1000,
   parameter cfp_quad_t PARALLEL_IO_BLOCK_OFS = 32'h0000_1100,
   parameter cfp_quad_t STROBE_BLOCK_OFS = 32'h0000_1200
) (
   input wire logic clk_i, // 100 mhz clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic [`CFP_ADDR_W-1:0] s_axi_awaddr_i, // write address
   input wire logic [2:0] s_axi_awprot_i, // write protection, unused
   input wire logic s_axi_awvalid_i, // write address valid
   output logic s_axi_awready_o, // write address ready
   input wire logic [31:0] s_axi_wdata_i, // write data
   input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
   input wire logic s_axi_wvalid_i, // write data valid
   output logic s_axi_wready_o, // write data ready
   output logic [1:0] s_axi_bresp_o, // write response
   output logic s_axi_bvalid_o, // write response valid
   input wire logic s_axi_bready_i, // write response ready
   input wire logic [`CFP_ADDR_W-1:0] s_axi_araddr_i, // read address
   input wire logic [2:0] s_axi_arprot_i, // read protection, unused
   input wire logic s_axi_arvalid_i, // read address valid
   output logic s_axi_arready_o, // read address ready
   output logic [31:0] s_axi_rdata_o, // read data
   output logic [1:0] s_axi_rresp_o, // read response
   output logic s_axi_rvalid_o, // read data valid
   input wire logic s_axi_rready_i // read data ready
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // quadlet field numbering counts from the msb
   function automatic cfp_quad_t quad_bit(input int unsigned field);
      quad_bit = 32'h8000_0000 >> field;
   endfunction

   // word-aligned compare; the two low address bits are ignored
   function automatic logic hit(input logic [`CFP_ADDR_W-1:0] addr,
                                input logic [`CFP_ADDR_W-1:0] ofs);
      hit = (addr[`CFP_ADDR_W-1:2] == ofs[`CFP_ADDR_W-1:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset

   logic rst_n;

   // the whole bank uses the synchronised release
   cfp_reset_sync u_reset_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .rst_n_o(rst_n)
   );

   ////////////////////////////////////////////////////////////////////////
   // video selection state

   cfp_sel_t fmt_q;
   cfp_sel_t fmt_d;
   cfp_sel_t mode_q;
   cfp_sel_t mode_d;
   logic sel_wr_en;
   cfp_quad_t sel_wr_data;
   logic [3:0] sel_wr_strb;
   cfp_quad_t sel_word;

   // byte lanes update only the fields they carry
   always_comb begin
      fmt_d = fmt_q;
      mode_d = mode_q;
      if (sel_wr_en) begin
         if (sel_wr_strb[0]) begin
            mode_d = sel_wr_data[`CFP_SEL_MODE_LSB +: 3];
         end
         if (sel_wr_strb[1]) begin
            fmt_d = sel_wr_data[`CFP_SEL_FMT_LSB +: 3];
         end
      end
   end

   // selection registers
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fmt_q <= `CFP_SEL_RESET;
         mode_q <= `CFP_SEL_RESET;
      end else begin
         fmt_q <= fmt_d;
         mode_q <= mode_d;
      end
   end

   // readback of the selection, unused bits zero
   always_comb begin
      sel_word = '0;
      sel_word[`CFP_SEL_MODE_LSB +: 3] = mode_q;
      sel_word[`CFP_SEL_FMT_LSB +: 3] = fmt_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // presence words

   logic colour_model;
   logic mono_selected;
   logic wb_present;
   cfp_quad_t feat_hi;
   cfp_quad_t feat_lo;
   cfp_quad_t opt_fn;

   assign colour_model = (MODEL_VARIANT == `CFP_VARIANT_COLOUR);
   // white balance is meaningless while a pure mono format is streaming
   assign mono_selected = (fmt_q == `CFP_MONO_FMT) &&
                          (mode_q == `CFP_MONO_MODE);
   assign wb_present = colour_model && !mono_selected;

   // feature-high: only the implemented controls are set, the rest stay 0
   always_comb begin
      feat_hi = '0;
      feat_hi |= quad_bit(`CFP_FB_BRIGHTNESS);
      feat_hi |= quad_bit(`CFP_FB_SHUTTER);
      feat_hi |= quad_bit(`CFP_FB_GAIN);
      feat_hi |= quad_bit(`CFP_FB_TRIGGER);
      if (wb_present) begin
         feat_hi |= quad_bit(`CFP_FB_WHITE_BALANCE);
      end
   end

   // feature-low: no lens, filter or still-capture controls exist
   always_comb begin
      feat_lo = '0;
   end

   // optional functions: parallel io and strobe, no serial io
   always_comb begin
      opt_fn = '0;
      opt_fn |= quad_bit(`CFP_FB_PARALLEL_IO);
      opt_fn |= quad_bit(`CFP_FB_STROBE);
   end

   ////////////////////////////////////////////////////////////////////////
   // write channel

   cfp_wr_state_e wr_state_q;
   cfp_wr_state_e wr_state_d;
   logic aw_got_q;
   logic aw_got_d;
   logic w_got_q;
   logic w_got_d;
   logic [`CFP_ADDR_W-1:0] awaddr_q;
   logic [`CFP_ADDR_W-1:0] awaddr_d;
   cfp_quad_t wdata_q;
   cfp_quad_t wdata_d;
   logic [3:0] wstrb_q;
   logic [3:0] wstrb_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;
   logic aw_take;
   logic w_take;
   logic [`CFP_ADDR_W-1:0] wr_addr;
   logic wr_mapped;

   // each channel is open until its beat is held; address and data in
   // either order
   assign s_axi_awready_o = (wr_state_q == CFP_WR_IDLE) && !aw_got_q;
   assign s_axi_wready_o = (wr_state_q == CFP_WR_IDLE) && !w_got_q;
   assign s_axi_bvalid_o = (wr_state_q == CFP_WR_RESP);
   assign s_axi_bresp_o = bresp_q;
   assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
   assign w_take = s_axi_wvalid_i && s_axi_wready_o;
   assign wr_addr = aw_take ? s_axi_awaddr_i : awaddr_q;

   // writes to inquiry words succeed but change nothing
   assign wr_mapped = hit(wr_addr, `CFP_OFS_FEAT_HI) ||
                      hit(wr_addr, `CFP_OFS_FEAT_LO) ||
                      hit(wr_addr, `CFP_OFS_OPT_FN) ||
                      hit(wr_addr, `CFP_OFS_ADV_PTR) ||
                      hit(wr_addr, `CFP_OFS_PIO_PTR) ||
                      hit(wr_addr, `CFP_OFS_STROBE_PTR) ||
                      hit(wr_addr, `CFP_OFS_VID_SEL);

   // write sequencing
   always_comb begin
      wr_state_d = wr_state_q;
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bresp_d = bresp_q;
      sel_wr_en = 1'b0;
      sel_wr_data = w_take ? s_axi_wdata_i : wdata_q;
      sel_wr_strb = w_take ? s_axi_wstrb_i : wstrb_q;
      unique case (wr_state_q)
         CFP_WR_IDLE: begin
            if (aw_take) begin
               aw_got_d = 1'b1;
               awaddr_d = s_axi_awaddr_i;
            end
            if (w_take) begin
               w_got_d = 1'b1;
               wdata_d = s_axi_wdata_i;
               wstrb_d = s_axi_wstrb_i;
            end
            if ((aw_got_q || aw_take) && (w_got_q || w_take)) begin
               sel_wr_en = hit(wr_addr, `CFP_OFS_VID_SEL);
               bresp_d = wr_mapped ? `CFP_RESP_OKAY : `CFP_RESP_SLVERR;
               aw_got_d = 1'b0;
               w_got_d = 1'b0;
               wr_state_d = CFP_WR_RESP;
            end
         end
         CFP_WR_RESP: begin
            if (s_axi_bready_i) begin
               wr_state_d = CFP_WR_IDLE;
            end
         end
      endcase
   end

   // write registers
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wr_state_q <= CFP_WR_IDLE;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bresp_q <= `CFP_RESP_OKAY;
      end else begin
         wr_state_q <= wr_state_d;
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel

   cfp_rd_state_e rd_state_q;
   cfp_rd_state_e rd_state_d;
   cfp_quad_t rdata_q;
   cfp_quad_t rdata_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;
   logic ar_take;
   cfp_quad_t rd_word;
   logic rd_mapped;

   assign s_axi_arready_o = (rd_state_q == CFP_RD_IDLE);
   assign s_axi_rvalid_o = (rd_state_q == CFP_RD_DATA);
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

   // read decode; the word is frozen at address time so a later
   // selection change cannot tear a pending answer
   always_comb begin
      rd_word = '0;
      rd_mapped = 1'b1;
      if (hit(s_axi_araddr_i, `CFP_OFS_FEAT_HI)) begin
         rd_word = feat_hi;
      end else if (hit(s_axi_araddr_i, `CFP_OFS_FEAT_LO)) begin
         rd_word = feat_lo;
      end else if (hit(s_axi_araddr_i, `CFP_OFS_OPT_FN)) begin
         rd_word = opt_fn;
      end else if (hit(s_axi_araddr_i, `CFP_OFS_ADV_PTR)) begin
         rd_word = VENDOR_BLOCK_OFS;
      end else if (hit(s_axi_araddr_i, `CFP_OFS_PIO_PTR)) begin
         rd_word = PARALLEL_IO_BLOCK_OFS;
      end else if (hit(s_axi_araddr_i, `CFP_OFS_STROBE_PTR)) begin
         rd_word = STROBE_BLOCK_OFS;
      end else if (hit(s_axi_araddr_i, `CFP_OFS_VID_SEL)) begin
         rd_word = sel_word;
      end else begin
         rd_mapped = 1'b0;
      end
   end

   // read sequencing
   always_comb begin
      rd_state_d = rd_state_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      unique case (rd_state_q)
         CFP_RD_IDLE: begin
            if (ar_take) begin
               rdata_d = rd_word;
               rresp_d = rd_mapped ? `CFP_RESP_OKAY : `CFP_RESP_SLVERR;
               rd_state_d = CFP_RD_DATA;
            end
         end
         CFP_RD_DATA: begin
            if (s_axi_rready_i) begin
               rd_state_d = CFP_RD_IDLE;
            end
         end
      endcase
   end

   // read registers
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_state_q <= CFP_RD_IDLE;
         rdata_q <= '0;
         rresp_q <= `CFP_RESP_OKAY;
      end else begin
         rd_state_q <= rd_state_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

endmodule // cfp_feature_inquiry

// ==== tb/cfp_inquiry_asserts.sv ====
// assertion checker for the feature presence inquiry bank, with its bind
`timescale 1ns/1ps
`include "cfp_inquiry_defines.svh"
module cfp_inquiry_asserts
   import cfp_inquiry_pkg::*;
#(
   parameter cfp_quad_t VENDOR_BLOCK_OFS = 32'h0000_1000,
   parameter cfp_quad_t PARALLEL_IO_BLOCK_OFS = 32'h0000_1100,
   parameter cfp_quad_t STROBE_BLOCK_OFS = 32'h0000_1200
) (
   input wire logic clk_i, // clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic [`CFP_ADDR_W-1:0] s_axi_awaddr_i, // write address
   input wire logic s_axi_awvalid_i, // write address valid
   input wire logic s_axi_awready_o, // write address ready
   input wire logic [1:0] s_axi_bresp_o, // write response
   input wire logic s_axi_bvalid_o, // write response valid
   input wire logic [`CFP_ADDR_W-1:0] s_axi_araddr_i, // read address
   input wire logic s_axi_arvalid_i, // read address valid
   input wire logic s_axi_arready_o, // read address ready
   input wire logic [31:0] s_axi_rdata_o, // read data
   input wire logic [1:0] s_axi_rresp_o, // read response
   input wire logic s_axi_rvalid_o, // read data valid
   input wire logic s_axi_rready_i // read data ready
);
   logic [`CFP_ADDR_W-1:0] ar_q, ar_d, aw_q, aw_d;

   // last accepted word addresses; the answer lags its address
   always_comb begin
      ar_d = ar_q;
      aw_d = aw_q;
      if (s_axi_arvalid_i && s_axi_arready_o)
         ar_d = {s_axi_araddr_i[`CFP_ADDR_W-1:2], 2'h0};
      if (s_axi_awvalid_i && s_axi_awready_o)
         aw_d = {s_axi_awaddr_i[`CFP_ADDR_W-1:2], 2'h0};
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ar_q <= 12'h000;
         aw_q <= 12'h000;
      end else begin
         ar_q <= ar_d;
         aw_q <= aw_d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   ////////////////////////////////////////////////////////////////////////
   rd_latency_a: assert property (
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   rd_hold_a: assert property (
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
      && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
      else $error("read answer dropped while stalled");
   hi_set_a: assert property (
      s_axi_rvalid_o && ar_q == `CFP_OFS_FEAT_HI |-> s_axi_rdata_o[31]
      && s_axi_rdata_o[24] && s_axi_rdata_o[23] && s_axi_rdata_o[19])
      else $error("feature high missing fixed bits");
   hi_clear_a: assert property (
      s_axi_rvalid_o && ar_q == `CFP_OFS_FEAT_HI
      |-> (s_axi_rdata_o & 32'h6E77_FFFF) == 32'h0000_0000)
      else $error("feature high absent bit set");
   lo_zero_a: assert property (
      s_axi_rvalid_o && ar_q == `CFP_OFS_FEAT_LO
      |-> s_axi_rdata_o == 32'h0000_0000)
      else $error("feature low not zero");
   opt_fn_a: assert property (
      s_axi_rvalid_o && ar_q == `CFP_OFS_OPT_FN
      |-> s_axi_rdata_o == 32'h5000_0000 && s_axi_rresp_o == `CFP_RESP_OKAY)
      else $error("optional function word wrong");
   ptr_values_a: assert property (
      s_axi_rvalid_o |->
      (ar_q != `CFP_OFS_ADV_PTR || s_axi_rdata_o == VENDOR_BLOCK_OFS)
      && (ar_q != `CFP_OFS_PIO_PTR || s_axi_rdata_o == PARALLEL_IO_BLOCK_OFS)
      && (ar_q != `CFP_OFS_STROBE_PTR || s_axi_rdata_o == STROBE_BLOCK_OFS))
      else $error("block pointer wrong");
   wr_okay_a: assert property (
      $rose(s_axi_bvalid_o) && aw_q inside {`CFP_OFS_FEAT_HI,
      `CFP_OFS_FEAT_LO, `CFP_OFS_OPT_FN, `CFP_OFS_ADV_PTR,
      `CFP_OFS_PIO_PTR, `CFP_OFS_STROBE_PTR}
      |-> s_axi_bresp_o == `CFP_RESP_OKAY)
      else $error("write to inquiry word not okay");

   // main scenarios reached
   cover property (s_axi_rvalid_o && ar_q == `CFP_OFS_FEAT_HI);
   cover property (s_axi_rvalid_o && !s_axi_rready_i);
   cover property (s_axi_bvalid_o && s_axi_bresp_o == `CFP_RESP_SLVERR);
endmodule // cfp_inquiry_asserts

bind cfp_feature_inquiry cfp_inquiry_asserts #(
   .VENDOR_BLOCK_OFS(VENDOR_BLOCK_OFS),
   .PARALLEL_IO_BLOCK_OFS(PARALLEL_IO_BLOCK_OFS),
   .STROBE_BLOCK_OFS(STROBE_BLOCK_OFS)
) cfp_inquiry_asserts_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_bresp_o(s_axi_bresp_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));

// ==== tb/camera_feature_presence_inquiry_test.sv ====
// self-checking bench for the feature presence inquiry bank
`timescale 1ns/1ps
`include "cfp_inquiry_defines.svh"
module camera_feature_presence_inquiry_test import cfp_inquiry_pkg::*;;
   localparam cfp_quad_t HI_MONO = 32'h8188_0000; // fields 0, 7, 8, 12
   localparam cfp_quad_t WB_BIT = 32'h1000_0000; // field 3
   localparam logic [1:0] OK = `CFP_RESP_OKAY;
   localparam logic [1:0] ERR = `CFP_RESP_SLVERR;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
   logic [2:0] aw_prot = 3'h0, ar_prot = 3'h0;
   logic [31:0] w_data = 32'h0, r_data, lfsr_q = 32'hFEBE, r, d;
   logic [3:0] w_strb = 4'h0;
   logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
   logic ar_valid = 1'b0, r_ready = 1'b0;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
   logic [1:0] b_resp, r_resp;
   logic [33:0] rd_q [$];
   logic [33:0] mono_q [$];
   logic [31:0] m_data;
   logic [1:0] m_resp;
   logic [1:0] wr_q [$];
   logic [11:0] ofs [6] = '{`CFP_OFS_FEAT_HI, `CFP_OFS_FEAT_LO,
      `CFP_OFS_OPT_FN, `CFP_OFS_ADV_PTR, `CFP_OFS_PIO_PTR,
      `CFP_OFS_STROBE_PTR};
   cfp_quad_t val [6] = '{HI_MONO | WB_BIT, 32'h0000_0000,
      32'h5000_0000, 32'h0012_3450, 32'h0012_3460, 32'h0012_3470};
   int fail_count = 0, tests_run = 0;

   cfp_feature_inquiry #(.MODEL_VARIANT(`CFP_VARIANT_COLOUR),
      .VENDOR_BLOCK_OFS(32'h0012_3450), .PARALLEL_IO_BLOCK_OFS(32'h0012_3460),
      .STROBE_BLOCK_OFS(32'h0012_3470)) cfp_feature_inquiry_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(aw_addr),
      .s_axi_awprot_i(aw_prot), .s_axi_awvalid_i(aw_valid),
      .s_axi_awready_o(aw_ready), .s_axi_wdata_i(w_data),
      .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid),
      .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp),
      .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
      .s_axi_araddr_i(ar_addr), .s_axi_arprot_i(ar_prot),
      .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready),
      .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
      .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready));

   // mono twin on the same bus; its handshakes match the colour copy, so
   // only its read answer is watched
   cfp_feature_inquiry #(.MODEL_VARIANT(`CFP_VARIANT_MONO),
      .VENDOR_BLOCK_OFS(32'h0012_3450), .PARALLEL_IO_BLOCK_OFS(32'h0012_3460),
      .STROBE_BLOCK_OFS(32'h0012_3470)) cfp_feature_inquiry_mono_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(aw_addr),
      .s_axi_awprot_i(aw_prot), .s_axi_awvalid_i(aw_valid),
      .s_axi_awready_o(), .s_axi_wdata_i(w_data),
      .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid),
      .s_axi_wready_o(), .s_axi_bresp_o(),
      .s_axi_bvalid_o(), .s_axi_bready_i(b_ready),
      .s_axi_araddr_i(ar_addr), .s_axi_arprot_i(ar_prot),
      .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(),
      .s_axi_rdata_o(m_data), .s_axi_rresp_o(m_resp),
      .s_axi_rvalid_o(), .s_axi_rready_i(r_ready));

   // 100 mhz clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // next value of the stimulus shift register
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q;
   endfunction

   task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t read got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_wr(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t bresp got %h exp %h", $time, got, exp);
      end
   endtask

   // handshake is judged at the falling edge, before the taking edge
   task automatic axi_wr(input logic [11:0] a, input cfp_quad_t dat,
      input logic [3:0] s, input logic [1:0] er);
      logic aw_p, w_p, b_p, aw_hs, w_hs, b_hs;
      wr_q.push_back(er);
      @(posedge clk_i);
      aw_addr <= a;
      aw_prot <= dat[6:4];
      w_data <= dat;
      w_strb <= s;
      {aw_valid, w_valid, b_ready} <= 3'h7;
      {aw_p, w_p, b_p} = 3'h7;
      while (aw_p || w_p || b_p) begin
         @(negedge clk_i);
         aw_hs = aw_p && aw_ready;
         w_hs = w_p && w_ready;
         b_hs = b_valid;
         @(posedge clk_i);
         if (aw_hs) aw_valid <= 1'b0;
         if (aw_hs) aw_p = 1'b0;
         if (w_hs) w_valid <= 1'b0;
         if (w_hs) w_p = 1'b0;
         if (b_hs) b_ready <= 1'b0;
         if (b_hs) b_p = 1'b0;
      end
   endtask

   // rready may come a few cycles late to stall the answer
   task automatic axi_rd(input logic [11:0] a, input cfp_quad_t ed,
      input logic [1:0] er);
      logic ar_p, r_p, ar_hs, r_hs;
      logic [31:0] x;
      int st;
      rd_q.push_back({er, ed});
      // the mono twin never reports white balance, whatever the selection
      mono_q.push_back({er, (a[11:2] == ofs[0][11:2]) ? ed & ~WB_BIT : ed});
      x = rnd();
      st = int'(x[1:0]);
      @(posedge clk_i);
      ar_addr <= a;
      ar_prot <= x[4:2];
      ar_valid <= 1'b1;
      r_ready <= (st == 0);
      {ar_p, r_p} = 2'h3;
      while (ar_p || r_p) begin
         @(negedge clk_i);
         ar_hs = ar_p && ar_ready;
         r_hs = r_ready && r_valid;
         @(posedge clk_i);
         if (ar_hs) ar_valid <= 1'b0;
         if (ar_hs) ar_p = 1'b0;
         if (r_hs) r_ready <= 1'b0;
         if (r_hs) r_p = 1'b0;
         else if (!ar_p && st == 0) r_ready <= 1'b1;
         else if (!ar_p) st--;
      end
   endtask

   // results are matched against the oldest outstanding note
   always @(negedge clk_i) begin
      if (r_valid && r_ready) begin
         cmp_rd({r_resp, r_data}, rd_q.pop_front());
         cmp_rd({m_resp, m_data}, mono_q.pop_front());
      end
      if (b_valid && b_ready) cmp_wr(b_resp, wr_q.pop_front());
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      fail_count++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 6; i++) axi_rd(ofs[i], val[i], OK);
      axi_rd(12'h407, val[0], OK);
      $display("test reset_values done");
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         axi_wr(ofs[i], r, r[3:0], OK);
         axi_rd(ofs[i], val[i], OK);
      end
      $display("test write_ignored done");
      axi_rd(12'h400, 32'h0, ERR);
      axi_wr(12'h410, rnd(), 4'hF, ERR);
      $display("test unmapped done");
      for (int k = 0; k < 10; k++) begin
         d = (k == 0) ? 32'h0000_0700 : rnd() & 32'h0000_0707;
         axi_wr(`CFP_OFS_VID_SEL, d, 4'hF, OK);
         axi_rd(`CFP_OFS_VID_SEL, d, OK);
         axi_rd(ofs[0], (d == 32'h700) ? HI_MONO : val[0], OK);
      end
      $display("test selection done");
      axi_wr(`CFP_OFS_VID_SEL, 32'h0000_0700, 4'hF, OK);
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      axi_rd(ofs[0], val[0], OK);
      axi_rd(`CFP_OFS_VID_SEL, 32'h0, OK);
      $display("test mid_reset done");
      summarize();
   end
endmodule // camera_feature_presence_inquiry_test
